// ==== slc_params.svh ====
`ifndef SLC_PARAMS_SVH
`define SLC_PARAMS_SVH
// Register numbers
`define SLC_OFS_DEBUG 8'h1f
`define SLC_OFS_SW 8'h20
`define SLC_OFS_PR 8'h40
`define SLC_OFS_EXT 8'h80
`define SLC_NLINK 8
// Debug origin bits
`define SLC_DBG_T0 0
`define SLC_DBG_T1 1
// Link state and route fields
`define SLC_KIND_HI 25
`define SLC_KIND_LO 24
`define SLC_DEST_HI 23
`define SLC_DEST_LO 16
`define SLC_DIR_HI 11
`define SLC_DIR_LO 8
`define SLC_NET_HI 5
`define SLC_NET_LO 4
`define SLC_JUNK 2
`define SLC_DBUSY 1
`define SLC_SBUSY 0
// External port setup fields
`define SLC_EN 31
`define SLC_FIVE 30
`define SLC_RXERR 27
`define SLC_CRISS 26
`define SLC_CRHELD 25
`define SLC_GREET 24
`define SLC_RXRST 23
`define SLC_SYM_HI 21
`define SLC_SYM_LO 11
`define SLC_TOK_HI 10
`define SLC_TOK_LO 0
// Reset values
`define SLC_RST_DIR 4'h0
`define SLC_RST_NET 2'h0
`define SLC_RST_GAP 11'h000
`define SLC_RST_DBG 2'h0
`define SLC_GAP_ONE 12'h001
`endif

// ==== slc_pkg.sv ====
package slc_pkg;
  typedef enum logic [1:0] {
    SLC_KIND_SWITCH = 2'h0,
    SLC_KIND_PROC = 2'h1,
    SLC_KIND_SWCTL = 2'h2,
    SLC_KIND_UNDEF = 2'h3
  } slc_kind_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } slc_bus_req_t;

  typedef struct packed {
    slc_kind_t kind;
    logic [7:0] dest;
    logic junk;
    logic dstBusy;
    logic srcBusy;
  } slc_link_stat_t;

  typedef struct packed {
    logic rxErr;
    logic creditIssued;
    logic creditGranted;
  } slc_ext_evt_t;

  typedef struct packed {
    logic enable;
    logic fiveWire;
    logic txAllowed;
    logic [11:0] symGap;
    logic [11:0] tokGap;
  } slc_ext_ctl_t;
endpackage

// ==== slc_regs.sv ====
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "slc_params.svh"

// How it works
// - Debug origin bits show which tile raised the latest chip-wide halt event.
// - Link state word shows source target kind in bits 25:24.
// - Link state word shows destination link number in bits 23:16.
// - Switch links hold a writable four-bit direction, reset zero.
// - Switch and processor links hold a writable two-bit network, reset zero.
// - Junk flag in bit 2 follows the link's discard state.
// - Bit 1 shows the destination side busy.
// - Bit 0 shows the source side busy.
// - Eight switch link words at consecutive numbers from 0x20.
// - Eight processor link words from 0x40, without direction field.
// - External port bit 31 enables the port and steers its pin muxing.
// - Bit 30 picks two-wire (0) or five-wire (1), reset zero.
// - Receive error flag sets on overflow or illegal token.
// - Flag shows local end has issued credit, reset zero.
// - Flag shows local end holds credit; sending only while held.
// - Writing one to bit 24 drops held credit and sends greeting token.
// - Writing one to bit 23 resets the receiver.
// - Symbol gap field holds minimum idle clocks minus one.
// - Token gap field holds minimum idle clocks minus one.
// - Eight external port setup words from 0x80.
module slc_regs (
  input wire logic sys_clk,
  input wire logic reset,
  input wire slc_pkg::slc_bus_req_t busReq,
  output logic [31:0] rdData,
  input wire logic dbgEvent,
  input wire logic dbgTile,
  input wire slc_pkg::slc_link_stat_t [`SLC_NLINK-1:0] swStat,
  input wire slc_pkg::slc_link_stat_t [`SLC_NLINK-1:0] prStat,
  output logic [`SLC_NLINK-1:0][3:0] swDir,
  output logic [`SLC_NLINK-1:0][1:0] swNet,
  output logic [`SLC_NLINK-1:0][1:0] prNet,
  input wire slc_pkg::slc_ext_evt_t [`SLC_NLINK-1:0] extEvt,
  output var slc_pkg::slc_ext_ctl_t [`SLC_NLINK-1:0] extCtl,
  output logic [`SLC_NLINK-1:0] sendGreeting,
  output logic [`SLC_NLINK-1:0] rxReset
);

  // Bank match on the upper five address bits
  function automatic logic inBank(input logic [7:0] a, input logic [7:0] base);
    return a[7:3] == base[7:3];
  endfunction

  // Read-only link state word, reserved bits zero
  function automatic logic [31:0] statWord(input slc_pkg::slc_link_stat_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`SLC_KIND_HI:`SLC_KIND_LO] = s.kind;
    w[`SLC_DEST_HI:`SLC_DEST_LO] = s.dest;
    w[`SLC_JUNK] = s.junk;
    w[`SLC_DBUSY] = s.dstBusy;
    w[`SLC_SBUSY] = s.srcBusy;
    return w;
  endfunction

  // Field minus one back to a cycle count
  function automatic logic [11:0] gapCycles(input logic [10:0] f);
    return {1'b0, f} + `SLC_GAP_ONE;
  endfunction

  logic [1:0] dbgSrc_r;
  logic [`SLC_NLINK-1:0][3:0] swDir_r;
  logic [`SLC_NLINK-1:0][1:0] swNet_r;
  logic [`SLC_NLINK-1:0][1:0] prNet_r;
  logic [`SLC_NLINK-1:0] extEn_r;
  logic [`SLC_NLINK-1:0] extFive_r;
  logic [`SLC_NLINK-1:0] extRxErr_r;
  logic [`SLC_NLINK-1:0] extCrIss_r;
  logic [`SLC_NLINK-1:0] extCrHeld_r;
  logic [`SLC_NLINK-1:0][10:0] extSym_r;
  logic [`SLC_NLINK-1:0][10:0] extTok_r;
  logic [`SLC_NLINK-1:0] greet_r;
  logic [`SLC_NLINK-1:0] rxRst_r;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;
  logic [2:0] busIdx;
  logic hitDbg;
  logic hitSw;
  logic hitPr;
  logic hitExt;
  logic wrSw;
  logic wrPr;
  logic wrExt;

  // Address decode
  assign busIdx = busReq.addr[2:0];
  assign hitDbg = busReq.addr == `SLC_OFS_DEBUG;
  assign hitSw = inBank(busReq.addr, `SLC_OFS_SW);
  assign hitPr = inBank(busReq.addr, `SLC_OFS_PR);
  assign hitExt = inBank(busReq.addr, `SLC_OFS_EXT);
  assign wrSw = busReq.wr && hitSw;
  assign wrPr = busReq.wr && hitPr;
  assign wrExt = busReq.wr && hitExt;

  // Debug origin: hardware event wins over a software write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dbgSrc_r <= `SLC_RST_DBG;
    end else if (dbgEvent) begin
      dbgSrc_r <= 2'h0;
      dbgSrc_r[`SLC_DBG_T1] <= dbgTile;
      dbgSrc_r[`SLC_DBG_T0] <= !dbgTile;
    end else if (busReq.wr && hitDbg) begin
      dbgSrc_r <= busReq.wdata[`SLC_DBG_T1:`SLC_DBG_T0];
    end
  end

  // Switch link direction and network
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < `SLC_NLINK; i++) begin
        swDir_r[i] <= `SLC_RST_DIR;
        swNet_r[i] <= `SLC_RST_NET;
      end
    end else if (wrSw) begin
      swDir_r[busIdx] <= busReq.wdata[`SLC_DIR_HI:`SLC_DIR_LO];
      swNet_r[busIdx] <= busReq.wdata[`SLC_NET_HI:`SLC_NET_LO];
    end
  end

  // Processor link network
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < `SLC_NLINK; i++) begin
        prNet_r[i] <= `SLC_RST_NET;
      end
    end else if (wrPr) begin
      prNet_r[busIdx] <= busReq.wdata[`SLC_NET_HI:`SLC_NET_LO];
    end
  end

  // External port setup fields
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < `SLC_NLINK; i++) begin
        extEn_r[i] <= 1'b0;
        extFive_r[i] <= 1'b0;
        extSym_r[i] <= `SLC_RST_GAP;
        extTok_r[i] <= `SLC_RST_GAP;
      end
    end else if (wrExt) begin
      extEn_r[busIdx] <= busReq.wdata[`SLC_EN];
      extFive_r[busIdx] <= busReq.wdata[`SLC_FIVE];
      extSym_r[busIdx] <= busReq.wdata[`SLC_SYM_HI:`SLC_SYM_LO];
      extTok_r[busIdx] <= busReq.wdata[`SLC_TOK_HI:`SLC_TOK_LO];
    end
  end

  // Write-only command pulses, one cycle each
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      greet_r <= '0;
      rxRst_r <= '0;
    end else begin
      for (int i = 0; i < `SLC_NLINK; i++) begin
        greet_r[i] <= wrExt && busIdx == i[2:0] && busReq.wdata[`SLC_GREET];
        rxRst_r[i] <= wrExt && busIdx == i[2:0] && busReq.wdata[`SLC_RXRST];
      end
    end
  end

  // Sticky link flags; a link event wins over a clearing write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      extRxErr_r <= '0;
      extCrIss_r <= '0;
      extCrHeld_r <= '0;
    end else begin
      for (int i = 0; i < `SLC_NLINK; i++) begin
        if (extEvt[i].rxErr) begin
          extRxErr_r[i] <= 1'b1;
        end else if (rxRst_r[i]) begin
          extRxErr_r[i] <= 1'b0;
        end
        if (extEvt[i].creditIssued) begin
          extCrIss_r[i] <= 1'b1;
        end else if (rxRst_r[i]) begin
          extCrIss_r[i] <= 1'b0;
        end
        if (extEvt[i].creditGranted) begin
          extCrHeld_r[i] <= 1'b1;
        end else if (greet_r[i]) begin
          extCrHeld_r[i] <= 1'b0;
        end
      end
    end
  end

  // Read mux; write-only and reserved bits give zero
  always_comb begin
    rdData_nxt = 32'h0000_0000;
    if (hitDbg) begin
      rdData_nxt[`SLC_DBG_T1:`SLC_DBG_T0] = dbgSrc_r;
    end else if (hitSw) begin
      rdData_nxt = statWord(swStat[busIdx]);
      rdData_nxt[`SLC_DIR_HI:`SLC_DIR_LO] = swDir_r[busIdx];
      rdData_nxt[`SLC_NET_HI:`SLC_NET_LO] = swNet_r[busIdx];
    end else if (hitPr) begin
      rdData_nxt = statWord(prStat[busIdx]);
      rdData_nxt[`SLC_NET_HI:`SLC_NET_LO] = prNet_r[busIdx];
    end else if (hitExt) begin
      rdData_nxt[`SLC_EN] = extEn_r[busIdx];
      rdData_nxt[`SLC_FIVE] = extFive_r[busIdx];
      rdData_nxt[`SLC_RXERR] = extRxErr_r[busIdx];
      rdData_nxt[`SLC_CRISS] = extCrIss_r[busIdx];
      rdData_nxt[`SLC_CRHELD] = extCrHeld_r[busIdx];
      rdData_nxt[`SLC_SYM_HI:`SLC_SYM_LO] = extSym_r[busIdx];
      rdData_nxt[`SLC_TOK_HI:`SLC_TOK_LO] = extTok_r[busIdx];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdData_r <= 32'h0000_0000;
    end else if (busReq.rd) begin
      rdData_r <= rdData_nxt;
    end else begin
      rdData_r <= 32'h0000_0000;
    end
  end

  // Outputs to the switch and the external ports
  assign rdData = rdData_r;
  assign swDir = swDir_r;
  assign swNet = swNet_r;
  assign prNet = prNet_r;
  assign sendGreeting = greet_r;
  assign rxReset = rxRst_r;
  always_comb begin
    for (int i = 0; i < `SLC_NLINK; i++) begin
      extCtl[i].enable = extEn_r[i];
      extCtl[i].fiveWire = extFive_r[i];
      extCtl[i].txAllowed = extEn_r[i] && extCrHeld_r[i];
      extCtl[i].symGap = gapCycles(extSym_r[i]);
      extCtl[i].tokGap = gapCycles(extTok_r[i]);
    end
  end

  // Checks
  a_debug_tile: assert property (@(posedge sys_clk) disable iff (reset)
    dbgEvent |=> dbgSrc_r == ($past(dbgTile) ? 2'h2 : 2'h1))
    else $error("debug origin wrong after event");

  a_kind_read: assert property (@(posedge sys_clk) disable iff (reset)
    (busReq.rd && hitSw) |=>
      rdData[`SLC_KIND_HI:`SLC_KIND_LO] == $past(swStat[busIdx].kind))
    else $error("target kind not read back");

  a_dest_read: assert property (@(posedge sys_clk) disable iff (reset)
    (busReq.rd && hitPr) |=>
      rdData[`SLC_DEST_HI:`SLC_DEST_LO] == $past(prStat[busIdx].dest))
    else $error("destination not read back");

  a_dir_store: assert property (@(posedge sys_clk) disable iff (reset)
    wrSw |=> swDir[$past(busIdx)] == $past(busReq.wdata[`SLC_DIR_HI:`SLC_DIR_LO]))
    else $error("direction not stored");

  a_busy_flags: assert property (@(posedge sys_clk) disable iff (reset)
    (busReq.rd && hitSw) |=>
      rdData[`SLC_SBUSY] == $past(swStat[busIdx].srcBusy) &&
      rdData[`SLC_DBUSY] == $past(swStat[busIdx].dstBusy))
    else $error("busy flags wrong");

  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (reset)
    (busReq.rd && !hitDbg && !hitSw && !hitPr && !hitExt) |=> rdData == 32'h0)
    else $error("unmapped read not zero");

  a_greet_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    (wrExt && busReq.wdata[`SLC_GREET]) |=>
      sendGreeting == (8'h01 << $past(busIdx)) ##1
      (sendGreeting == 8'h00 || $past(wrExt && busReq.wdata[`SLC_GREET])))
    else $error("greeting pulse wrong");

  // Per-port flag checks, every external port watched
  for (genvar p = 0; p < `SLC_NLINK; p++) begin : g_port_chk
    a_greet_drop: assert property (@(posedge sys_clk) disable iff (reset)
      (sendGreeting[p] && !extEvt[p].creditGranted) |=> !extCtl[p].txAllowed)
      else $error("credit kept after greeting");

    a_tx_gate: assert property (@(posedge sys_clk) disable iff (reset)
      extCtl[p].txAllowed |-> $past(extEvt[p].creditGranted) || $past(extCtl[p].txAllowed)
        || $past(wrExt))
      else $error("transmit allowed without credit");

    a_rxerr_sticky: assert property (@(posedge sys_clk) disable iff (reset)
      extEvt[p].rxErr |=> extRxErr_r[p] ##1 (extRxErr_r[p] || $past(rxReset[p])))
      else $error("receive error not held");

    a_criss_sticky: assert property (@(posedge sys_clk) disable iff (reset)
      extEvt[p].creditIssued |=> extCrIss_r[p] ##1 (extCrIss_r[p] || $past(rxReset[p])))
      else $error("issued credit not held");

    a_rxrst_clear: assert property (@(posedge sys_clk) disable iff (reset)
      (rxReset[p] && !extEvt[p].rxErr && !extEvt[p].creditIssued) |=>
        !extRxErr_r[p] && !extCrIss_r[p])
      else $error("receiver reset left flags set");
  end

  a_tok_gap: assert property (@(posedge sys_clk) disable iff (reset)
    wrExt |=> extCtl[$past(busIdx)].tokGap ==
      {1'b0, $past(busReq.wdata[`SLC_TOK_HI:`SLC_TOK_LO])} + 12'h001)
    else $error("token gap not count plus one");

  a_read_once: assert property (@(posedge sys_clk) disable iff (reset)
    !busReq.rd |=> rdData == 32'h0)
    else $error("read data held too long");

  a_net_store: assert property (@(posedge sys_clk) disable iff (reset)
    wrPr |=> prNet[$past(busIdx)] == $past(busReq.wdata[`SLC_NET_HI:`SLC_NET_LO]))
    else $error("network not stored");

  a_sw_dest: assert property (@(posedge sys_clk) disable iff (reset)
    (busReq.rd && hitSw) |=>
      rdData[`SLC_DEST_HI:`SLC_DEST_LO] == $past(swStat[busIdx].dest))
    else $error("switch link destination not read back");

  a_pr_kind: assert property (@(posedge sys_clk) disable iff (reset)
    (busReq.rd && hitPr) |=>
      rdData[`SLC_KIND_HI:`SLC_KIND_LO] == $past(prStat[busIdx].kind))
    else $error("processor link kind not read back");

  a_junk_read: assert property (@(posedge sys_clk) disable iff (reset)
    (busReq.rd && hitPr) |=>
      rdData[`SLC_JUNK] == $past(prStat[busIdx].junk))
    else $error("junk flag not read back");

  a_pr_busy: assert property (@(posedge sys_clk) disable iff (reset)
    (busReq.rd && hitPr) |=>
      rdData[`SLC_DBUSY] == $past(prStat[busIdx].dstBusy) &&
      rdData[`SLC_SBUSY] == $past(prStat[busIdx].srcBusy))
    else $error("processor link busy flags wrong");

  a_pr_nodir: assert property (@(posedge sys_clk) disable iff (reset)
    (busReq.rd && hitPr) |=> rdData[`SLC_DIR_HI:`SLC_DIR_LO] == 4'h0)
    else $error("processor link shows a direction");

  a_enable_store: assert property (@(posedge sys_clk) disable iff (reset)
    wrExt |=> extCtl[$past(busIdx)].enable == $past(busReq.wdata[`SLC_EN]))
    else $error("port enable not stored");

  a_five_store: assert property (@(posedge sys_clk) disable iff (reset)
    wrExt |=> extCtl[$past(busIdx)].fiveWire == $past(busReq.wdata[`SLC_FIVE]))
    else $error("port width not stored");

  a_sym_gap: assert property (@(posedge sys_clk) disable iff (reset)
    wrExt |=> extCtl[$past(busIdx)].symGap ==
      {1'b0, $past(busReq.wdata[`SLC_SYM_HI:`SLC_SYM_LO])} + 12'h001)
    else $error("symbol gap not count plus one");

  a_ext_read: assert property (@(posedge sys_clk) disable iff (reset)
    (busReq.rd && hitExt) |=> rdData[`SLC_EN] == $past(extCtl[busIdx].enable) &&
      rdData[29:28] == 2'h0 && rdData[`SLC_GREET:22] == 3'h0)
    else $error("external port word wrong");

  a_rxrst_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    (wrExt && busReq.wdata[`SLC_RXRST]) |=>
      rxReset == (8'h01 << $past(busIdx)))
    else $error("receiver reset pulse wrong");

  a_dbg_write: assert property (@(posedge sys_clk) disable iff (reset)
    (busReq.wr && hitDbg && !dbgEvent) |=> dbgSrc_r == $past(busReq.wdata[1:0]))
    else $error("debug origin write lost");

  c_debug_event: cover property (@(posedge sys_clk) disable iff (reset) dbgEvent);
  c_greeting: cover property (@(posedge sys_clk) disable iff (reset) sendGreeting != 8'h00);
  c_rx_reset: cover property (@(posedge sys_clk) disable iff (reset) rxReset != 8'h00);
  c_sw_read: cover property (@(posedge sys_clk) disable iff (reset) busReq.rd && hitSw);
  c_credit_held: cover property (@(posedge sys_clk) disable iff (reset) extCrHeld_r != 8'h00);

endmodule
`default_nettype wire

// ==== slc_remote_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Far end of the external ports: answers a greeting with fresh credit
module slc_remote_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] sendGreeting,
  input wire logic slow,
  input wire logic [7:0] errReq,
  input wire logic [7:0] issueReq,
  output var slc_pkg::slc_ext_evt_t [7:0] extEvt
);
  logic [7:0][2:0] wait_r;

  // Credit arrives two or seven cycles after a greeting
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 8; i++) begin
      extEvt[i].rxErr <= errReq[i] & ~reset;
      extEvt[i].creditIssued <= issueReq[i] & ~reset;
      extEvt[i].creditGranted <= (wait_r[i] == 3'h1) & ~reset;
      if (reset) begin
        wait_r[i] <= 3'h0;
      end else if (sendGreeting[i]) begin
        wait_r[i] <= slow ? 3'h6 : 3'h1;
      end else if (wait_r[i] != 3'h0) begin
        wait_r[i] <= wait_r[i] - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== slc_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  slc_pkg::slc_bus_req_t busReq = '0;
  logic [31:0] rdData;
  logic dbgEvent = 1'b0;
  logic dbgTile = 1'b0;
  slc_pkg::slc_link_stat_t [7:0] swStat = '0;
  slc_pkg::slc_link_stat_t [7:0] prStat = '0;
  logic [7:0][3:0] swDir;
  logic [7:0][1:0] swNet;
  logic [7:0][1:0] prNet;
  slc_pkg::slc_ext_evt_t [7:0] extEvt;
  slc_pkg::slc_ext_ctl_t [7:0] extCtl;
  logic [7:0] sendGreeting;
  logic [7:0] rxReset;
  logic slow = 1'b0;
  logic [7:0] errReq = '0;
  logic [7:0] issueReq = '0;
  logic [3:0] n;
  logic [10:0] sym;
  logic [10:0] tok;
  int fails = 0;
  int totalChecks = 0;

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  slc_regs dut (.sys_clk(sys_clk), .reset(reset), .busReq(busReq), .rdData(rdData),
    .dbgEvent(dbgEvent), .dbgTile(dbgTile), .swStat(swStat), .prStat(prStat),
    .swDir(swDir), .swNet(swNet), .prNet(prNet), .extEvt(extEvt), .extCtl(extCtl),
    .sendGreeting(sendGreeting), .rxReset(rxReset));

  slc_remote_model far (.sys_clk(sys_clk), .reset(reset), .sendGreeting(sendGreeting),
    .slow(slow), .errReq(errReq), .issueReq(issueReq), .extEvt(extEvt));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    totalChecks++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // One-cycle write, returns inside the cycle after it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    busReq.wr <= 1'b0;
    #1;
  endtask

  // One-cycle read, data compared in the cycle after
  task automatic rdChk(input logic [7:0] a, input logic [31:0] want);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    busReq.rd <= 1'b0;
    #1;
    check(rdData, want);
  endtask

  task automatic endOfTest();
    $display("Checks %0d, mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    endOfTest();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    check(32'({swNet, prNet}), 32'h0);
    check(swDir, 32'h0);
    for (int i = 0; i < 8; i++) begin
      check({5'h0, extCtl[i]}, {8'h0, 12'h001, 12'h001});
      rdChk(8'(8'h80 + i), 32'h0);
      swStat[i] <= {2'(i), 8'(8'h10 + i), 3'(i)};
      prStat[i] <= {~2'(i), 8'(8'hf0 - i), ~3'(i)};
    end
    check(rdData, 32'h0);
    // Link words: writable fields, read-only state, no write through
    for (int i = 0; i < 8; i++) begin
      n = 4'(i);
      wr(8'(8'h20 + i), ~{20'h0, n, 2'h0, n[1:0], 4'h0});
      wr(8'(8'h40 + i), ~{20'h0, n, 2'h0, n[1:0], 4'h0});
      rdChk(8'(8'h20 + i), {6'h0, n[1:0], 8'(8'h10 + i), 4'h0, ~n, 2'h0, ~n[1:0], 1'b0, n[2:0]});
      rdChk(8'(8'h40 + i), {6'h0, ~n[1:0], 8'(8'hf0 - i), 10'h0, ~n[1:0], 1'b0, ~n[2:0]});
      check(32'({swDir[n[2:0]], swNet[n[2:0]], prNet[n[2:0]]}), 32'({~n, ~n[1:0], ~n[1:0]}));
    end
    wr(8'h30, 32'hffff_ffff);
    rdChk(8'h30, 32'h0);
    rdChk(8'h1e, 32'h0);
    // Halt event origin for each tile
    for (int t = 0; t < 2; t++) begin
      @(posedge sys_clk);
      dbgEvent <= 1'b1;
      dbgTile <= 1'(t);
      @(posedge sys_clk);
      dbgEvent <= 1'b0;
      rdChk(8'h1f, 32'(t + 1));
    end
    wr(8'h1f, 32'hffff_ffff);
    rdChk(8'h1f, 32'h3);
    // External setup, ones written to reserved and read-only bits
    for (int i = 0; i < 8; i++) begin
      sym = 11'(11'h7ff - i);
      tok = 11'(i * 11'h124);
      wr(8'(8'h80 + i), {4'hf, 4'he, 2'b01, sym, tok});
      check({5'h0, extCtl[i]}, {5'h0, 3'b110, {1'b0, sym} + 12'h1, {1'b0, tok} + 12'h1});
      rdChk(8'(8'h80 + i), {2'b11, 8'h0, sym, tok});
    end
    // Greeting answered fast, then slowly, then port disabled
    wr(8'h82, 32'hc100_0000);
    check(sendGreeting, 32'h4);
    repeat (4) @(posedge sys_clk);
    #1;
    check(extCtl[2].txAllowed, 32'h1);
    rdChk(8'h82, 32'hc200_0000);
    @(posedge sys_clk);
    slow <= 1'b1;
    wr(8'h82, 32'hc100_0000);
    repeat (2) @(posedge sys_clk);
    #1;
    check(extCtl[2].txAllowed, 32'h0);
    rdChk(8'h82, 32'hc000_0000);
    repeat (8) @(posedge sys_clk);
    rdChk(8'h82, 32'hc200_0000);
    wr(8'h82, 32'h0);
    check({extCtl[2].enable, extCtl[2].txAllowed}, 32'h0);
    rdChk(8'h82, 32'h0200_0000);
    // Receive error and issued credit, then receiver reset
    wr(8'h83, 32'h0);
    @(posedge sys_clk);
    errReq <= 8'h08;
    issueReq <= 8'h08;
    @(posedge sys_clk);
    errReq <= 8'h0;
    issueReq <= 8'h0;
    rdChk(8'h83, 32'h0c00_0000);
    wr(8'h83, 32'h0080_0000);
    check(rxReset, 32'h8);
    rdChk(8'h83, 32'h0);
    endOfTest();
  end
endmodule
`default_nettype wire
